/* design/sfcp_consts.svh */
// Constants for the serial flash command port: opcodes, field positions, timing counts
`ifndef SFCP_CONSTS_SVH
`define SFCP_CONSTS_SVH

// Opcodes
`define SFCP_OP_BLK_ERASE   8'h50
`define SFCP_OP_PAGE_RD     8'h52
`define SFCP_OP_XFR_B1      8'h53
`define SFCP_OP_BUF1_RD     8'h54
`define SFCP_OP_XFR_B2      8'h55
`define SFCP_OP_BUF2_RD     8'h56
`define SFCP_OP_STAT_RD     8'h57
`define SFCP_OP_RW_B1       8'h58
`define SFCP_OP_RW_B2       8'h59
`define SFCP_OP_CMP_B1      8'h60
`define SFCP_OP_CMP_B2      8'h61
`define SFCP_OP_CONT_RD     8'h68
`define SFCP_OP_PG_ERASE    8'h81
`define SFCP_OP_PROG_THR_B1 8'h82
`define SFCP_OP_PROG_E_B1   8'h83
`define SFCP_OP_BUF1_WR     8'h84
`define SFCP_OP_PROG_THR_B2 8'h85
`define SFCP_OP_PROG_E_B2   8'h86
`define SFCP_OP_BUF2_WR     8'h87
`define SFCP_OP_PROG_N_B1   8'h88
`define SFCP_OP_PROG_N_B2   8'h89
`define SFCP_OP_PAGE_RD_S   8'hD2
`define SFCP_OP_BUF1_RD_S   8'hD4
`define SFCP_OP_BUF2_RD_S   8'hD6
`define SFCP_OP_STAT_RD_S   8'hD7
`define SFCP_OP_CONT_RD_S   8'hE8

// Address field positions within the 24-bit address
`define SFCP_PAGE_MSB      18
`define SFCP_PAGE_LSB      9
`define SFCP_BYTE_MSB      8
`define SFCP_BLOCK_LSB     12
// Dummy byte counts and framing counts
`define SFCP_ARRAY_DUMMY   3'h4
`define SFCP_BUF_DUMMY     3'h1
`define SFCP_ADDR_BYTES    3'h3
// Pages below this are locked while the protect pin is low
`define SFCP_PROT_PAGES    10'h100
// Busy cycle count for self-timed work (shortened model of array time)
`define SFCP_BUSY_CYCLES   16'h0400
// Status bit that carries the compare outcome
`define SFCP_STAT_CMP_BIT  6
`define SFCP_STAT_RDY_BIT  7

`endif

/* design/sfcp_pkg.sv */
// Types shared by the serial flash command port
package sfcp_pkg;
  // Command phase state, Gray along opcode-address-dummy-data
  typedef enum logic [2:0] {
    SFCP_IDLE  = 3'b000,
    SFCP_OPC   = 3'b001,
    SFCP_ADDR  = 3'b011,
    SFCP_DUMMY = 3'b010,
    SFCP_DATA  = 3'b110,
    SFCP_IGN   = 3'b111
  } sfcp_state_t;

  // Self-timed action class
  typedef enum logic [2:0] {
    SFCP_ACT_NONE,
    SFCP_ACT_XFR,
    SFCP_ACT_CMP,
    SFCP_ACT_PROG,
    SFCP_ACT_ERASE
  } sfcp_act_t;
endpackage

/* design/sfcp_port.sv */
// Serial command front-end of a two-buffer page flash
// Function
// - Opcode, five reserved, ten page, nine byte
// - Page field selects page; block uses upper seven
// - Buffer commands use byte bits; dummy 4/1
// - All input on serial in only
// - Sample rising edge, shift on falling
// - Deselected: ignore input, output off
// - Self-timed work starts at select rise
// - Protect low locks lowest 256 pages
// - Reset pin aborts and holds idle
// - Ready/busy pulled low during self-timed work
// - Busy blocks array and its buffer
// - After reset mode 3, output off
// - Select fall samples clock idle level
// - Compare end updates status bit six
`timescale 1ns/1ps
`include "sfcp_consts.svh"
module sfcp_port (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so_o,
  output logic            so_oe,
  // Control pins
  input  wire logic       wp_n,
  input  wire logic       reset_pin_n,
  output logic            rdy_busy_o,
  output logic            rdy_busy_oe,
  // Received data stream
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [7:0]      wr_data,
  // Command description for the array side
  output logic [7:0]      cmd_opcode,
  output logic [9:0]      page_select_bits,
  output logic [8:0]      byte_offset_bits,
  output logic            cmd_refused,
  // Read data supplied by the array side
  input  wire logic [7:0] rd_data,
  output logic            rd_req,
  input  wire logic       cmp_equal,
  output logic            mode3
);
  // Synchronisers: first stage read only by second
  logic [1:0] sck_s_reg, cs_s_reg, si_s_reg, wp_s_reg, rp_s_reg;
  logic       sck_d_reg, cs_d_reg;     // Delayed for edges
  logic       sck_r, sck_f, cs_f, cs_r; // Edge pulses
  logic       rst_pin;                  // Reset pin active
  sfcp_pkg::sfcp_state_t state_reg;     // Command phase
  logic [7:0]  sh_reg;                  // Input shift register
  logic [2:0]  bit_reg;                 // Bit count in byte
  logic [2:0]  cnt_reg;                 // Byte count in phase
  logic [23:0] addr_reg;                // Collected address
  logic [7:0]  out_reg;                 // Output shift register
  logic        oe_reg;                  // Output enable
  logic        mode3_reg;               // Current clock mode
  logic        busy_reg;                // Self-timed busy
  logic [15:0] busy_cnt_reg;            // Busy timer
  logic        busy_buf2_reg;           // Buffer held by busy
  sfcp_pkg::sfcp_act_t act_reg;         // Pending self-timed work
  logic [7:0]  status_reg;              // Status byte
  logic        byte_done;               // Full byte received
  logic [7:0]  byte_in;                 // Byte being completed
  logic        buf_ok;                  // Buffer commands serviced

  // Opcode classification
  function automatic logic is_known(input logic [7:0] op);
    case (op)
      `SFCP_OP_BLK_ERASE, `SFCP_OP_PAGE_RD, `SFCP_OP_XFR_B1, `SFCP_OP_BUF1_RD, `SFCP_OP_XFR_B2,
      `SFCP_OP_BUF2_RD, `SFCP_OP_STAT_RD, `SFCP_OP_RW_B1, `SFCP_OP_RW_B2, `SFCP_OP_CMP_B1,
      `SFCP_OP_CMP_B2, `SFCP_OP_CONT_RD, `SFCP_OP_PG_ERASE, `SFCP_OP_PROG_THR_B1, `SFCP_OP_PROG_E_B1,
      `SFCP_OP_BUF1_WR, `SFCP_OP_PROG_THR_B2, `SFCP_OP_PROG_E_B2, `SFCP_OP_BUF2_WR, `SFCP_OP_PROG_N_B1,
      `SFCP_OP_PROG_N_B2, `SFCP_OP_PAGE_RD_S, `SFCP_OP_BUF1_RD_S, `SFCP_OP_BUF2_RD_S,
      `SFCP_OP_STAT_RD_S, `SFCP_OP_CONT_RD_S: is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction

  // Dummy bytes needed before read data
  function automatic logic [2:0] dummy_of(input logic [7:0] op);
    case (op)
      `SFCP_OP_PAGE_RD, `SFCP_OP_CONT_RD, `SFCP_OP_PAGE_RD_S, `SFCP_OP_CONT_RD_S: dummy_of = `SFCP_ARRAY_DUMMY;
      `SFCP_OP_BUF1_RD, `SFCP_OP_BUF2_RD, `SFCP_OP_BUF1_RD_S, `SFCP_OP_BUF2_RD_S: dummy_of = `SFCP_BUF_DUMMY;
      default: dummy_of = 3'h0;
    endcase
  endfunction

  // Buffer-only command and the buffer it names (1 = buffer 2)
  function automatic logic is_buf_cmd(input logic [7:0] op);
    case (op)
      `SFCP_OP_BUF1_RD, `SFCP_OP_BUF2_RD, `SFCP_OP_BUF1_RD_S, `SFCP_OP_BUF2_RD_S,
      `SFCP_OP_BUF1_WR, `SFCP_OP_BUF2_WR: is_buf_cmd = 1'b1;
      default: is_buf_cmd = 1'b0;
    endcase
  endfunction

  function automatic logic buf_sel(input logic [7:0] op);
    case (op)
      `SFCP_OP_BUF2_RD, `SFCP_OP_BUF2_RD_S, `SFCP_OP_BUF2_WR, `SFCP_OP_XFR_B2, `SFCP_OP_RW_B2,
      `SFCP_OP_CMP_B2, `SFCP_OP_PROG_THR_B2, `SFCP_OP_PROG_E_B2, `SFCP_OP_PROG_N_B2: buf_sel = 1'b1;
      default: buf_sel = 1'b0;
    endcase
  endfunction

  // Self-timed action for an opcode
  function automatic sfcp_pkg::sfcp_act_t act_of(input logic [7:0] op);
    case (op)
      `SFCP_OP_XFR_B1, `SFCP_OP_XFR_B2: act_of = sfcp_pkg::SFCP_ACT_XFR;
      `SFCP_OP_CMP_B1, `SFCP_OP_CMP_B2: act_of = sfcp_pkg::SFCP_ACT_CMP;
      `SFCP_OP_BLK_ERASE, `SFCP_OP_PG_ERASE: act_of = sfcp_pkg::SFCP_ACT_ERASE;
      `SFCP_OP_RW_B1, `SFCP_OP_RW_B2, `SFCP_OP_PROG_THR_B1, `SFCP_OP_PROG_THR_B2, `SFCP_OP_PROG_E_B1,
      `SFCP_OP_PROG_E_B2, `SFCP_OP_PROG_N_B1, `SFCP_OP_PROG_N_B2: act_of = sfcp_pkg::SFCP_ACT_PROG;
      default: act_of = sfcp_pkg::SFCP_ACT_NONE;
    endcase
  endfunction

  // Two-flop synchronisers for every pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_reg <= 2'h3;
      cs_s_reg  <= 2'h3;
      si_s_reg  <= 2'h0;
      wp_s_reg  <= 2'h0;
      rp_s_reg  <= 2'h0;
      sck_d_reg <= 1'b1;
      cs_d_reg  <= 1'b1;
    end else begin
      sck_s_reg <= {sck_s_reg[0], sck};
      cs_s_reg  <= {cs_s_reg[0], cs_n};
      si_s_reg  <= {si_s_reg[0], si};
      wp_s_reg  <= {wp_s_reg[0], wp_n};
      rp_s_reg  <= {rp_s_reg[0], reset_pin_n};
      sck_d_reg <= sck_s_reg[1];
      cs_d_reg  <= cs_s_reg[1];
    end
  end

  // deselect gating: edges count only while selected
  assign rst_pin   = !rp_s_reg[1];
  assign sck_r     = sck_s_reg[1] && !sck_d_reg && !cs_s_reg[1];
  assign sck_f     = !sck_s_reg[1] && sck_d_reg && !cs_s_reg[1];
  assign cs_f      = !cs_s_reg[1] && cs_d_reg;
  assign cs_r      = cs_s_reg[1] && !cs_d_reg;
  // input from serial in, MSB first
  assign byte_in   = {sh_reg[6:0], si_s_reg[1]};
  assign byte_done = sck_r && (bit_reg == 3'h7);
  // the other buffer stays usable during busy
  assign buf_ok    = !busy_reg || (is_buf_cmd(cmd_opcode) && (buf_sel(cmd_opcode) != busy_buf2_reg));

  // clock mode chosen at select fall, mode 3 after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode3_reg <= 1'b1;
    end else if (rst_pin) begin
      mode3_reg <= 1'b1;
    end else if (cs_f) begin
      mode3_reg <= sck_s_reg[1];
    end
  end

  // Command phase sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= sfcp_pkg::SFCP_IDLE;
      sh_reg     <= 8'h00;
      bit_reg    <= 3'h0;
      cnt_reg    <= 3'h0;
      addr_reg   <= 24'h000000;
      cmd_opcode <= 8'h00;
    end else if (rst_pin || cs_s_reg[1]) begin
      // reset pin holds idle; select fall needed
      state_reg <= (rst_pin || !cs_f) ? sfcp_pkg::SFCP_IDLE : state_reg;
      bit_reg   <= 3'h0;
    end else begin
      // only a fresh select fall leaves idle
      if (state_reg == sfcp_pkg::SFCP_IDLE && cs_f) begin
        state_reg <= sfcp_pkg::SFCP_OPC;
      end
      if (sck_r) begin
        sh_reg  <= byte_in;
        bit_reg <= bit_reg + 3'h1;
      end
      if (byte_done) begin
        case (state_reg)
          sfcp_pkg::SFCP_OPC: begin
            cmd_opcode <= byte_in;
            cnt_reg    <= 3'h0;
            // unknown opcode ignored until next select
            if (!is_known(byte_in)) begin
              state_reg <= sfcp_pkg::SFCP_IGN;
            end else if (byte_in == `SFCP_OP_STAT_RD || byte_in == `SFCP_OP_STAT_RD_S) begin
              state_reg <= sfcp_pkg::SFCP_DATA;
            end else begin
              state_reg <= sfcp_pkg::SFCP_ADDR;
            end
          end
          // three address bytes follow the opcode
          sfcp_pkg::SFCP_ADDR: begin
            addr_reg <= {addr_reg[15:0], byte_in};
            cnt_reg  <= cnt_reg + 3'h1;
            if (cnt_reg == `SFCP_ADDR_BYTES - 3'h1) begin
              cnt_reg   <= 3'h0;
              state_reg <= (dummy_of(cmd_opcode) != 3'h0) ? sfcp_pkg::SFCP_DUMMY : sfcp_pkg::SFCP_DATA;
            end
          end
          sfcp_pkg::SFCP_DUMMY: begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == dummy_of(cmd_opcode) - 3'h1) begin
              state_reg <= sfcp_pkg::SFCP_DATA;
            end
          end
          sfcp_pkg::SFCP_DATA: cnt_reg <= cnt_reg;
          sfcp_pkg::SFCP_IGN: cnt_reg <= cnt_reg;
          default: state_reg <= sfcp_pkg::SFCP_IDLE;
        endcase
      end
    end
  end

  // page and byte fields taken from the address
  assign page_select_bits = addr_reg[`SFCP_PAGE_MSB:`SFCP_PAGE_LSB];
  assign byte_offset_bits = addr_reg[`SFCP_BYTE_MSB:0];
  assign mode3 = mode3_reg;

  // Write data bytes into the two-entry buffer; in_ready is unused, so a byte arriving while it is full is dropped
  sfcp_skid u_skid (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (byte_done && state_reg == sfcp_pkg::SFCP_DATA && is_buf_cmd(cmd_opcode) &&
                !(dummy_of(cmd_opcode) != 3'h0) && buf_ok),
    .in_ready  (),
    .in_data   (byte_in),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // output shifts on falling edges, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 8'h00;
      oe_reg  <= 1'b0;
      rd_req  <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      if (rst_pin || cs_s_reg[1]) begin
        oe_reg <= 1'b0;
      end else if (sck_f && state_reg == sfcp_pkg::SFCP_DATA && dummy_of(cmd_opcode) != 3'h0 ||
                   sck_f && state_reg == sfcp_pkg::SFCP_DATA &&
                   (cmd_opcode == `SFCP_OP_STAT_RD || cmd_opcode == `SFCP_OP_STAT_RD_S)) begin
        oe_reg <= buf_ok;
        if (bit_reg == 3'h0) begin
          out_reg <= (cmd_opcode == `SFCP_OP_STAT_RD || cmd_opcode == `SFCP_OP_STAT_RD_S) ?
                     status_reg : rd_data;
          rd_req  <= 1'b1;
        end else begin
          out_reg <= {out_reg[6:0], 1'b0};
        end
      end
    end
  end
  assign so_o  = out_reg[7];
  assign so_oe = oe_reg;

  // self-timed work launched at select rise, protect checked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg      <= 1'b0;
      busy_cnt_reg  <= 16'h0000;
      busy_buf2_reg <= 1'b0;
      act_reg       <= sfcp_pkg::SFCP_ACT_NONE;
      cmd_refused   <= 1'b0;
    end else if (rst_pin) begin
      busy_reg <= 1'b0;
      act_reg  <= sfcp_pkg::SFCP_ACT_NONE;
    end else if (busy_reg) begin
      busy_cnt_reg <= busy_cnt_reg - 16'h0001;
      if (busy_cnt_reg == 16'h0001) begin
        busy_reg <= 1'b0;
        act_reg  <= sfcp_pkg::SFCP_ACT_NONE;
      end
    end else if (cs_r && state_reg == sfcp_pkg::SFCP_DATA && act_of(cmd_opcode) != sfcp_pkg::SFCP_ACT_NONE) begin
      // lowest pages locked while protect pin low
      if ((act_of(cmd_opcode) == sfcp_pkg::SFCP_ACT_PROG || act_of(cmd_opcode) == sfcp_pkg::SFCP_ACT_ERASE) &&
          !wp_s_reg[1] && page_select_bits < `SFCP_PROT_PAGES) begin
        cmd_refused <= 1'b1;
      end else begin
        cmd_refused   <= 1'b0;
        busy_reg      <= 1'b1;
        busy_cnt_reg  <= `SFCP_BUSY_CYCLES;
        busy_buf2_reg <= buf_sel(cmd_opcode);
        act_reg       <= act_of(cmd_opcode);
      end
    end
  end
  // open-drain pin pulled low while busy
  assign rdy_busy_o  = 1'b0;
  assign rdy_busy_oe = busy_reg;

  // compare result lands in status bit six
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 8'h00;
    end else begin
      status_reg[`SFCP_STAT_RDY_BIT] <= !busy_reg;
      if (busy_reg && busy_cnt_reg == 16'h0001 && act_reg == sfcp_pkg::SFCP_ACT_CMP) begin
        status_reg[`SFCP_STAT_CMP_BIT] <= !cmp_equal;
      end
    end
  end
endmodule // sfcp_port

/* design/sfcp_skid.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sfcp_skid (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Filling side
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  // Draining side
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] mem_reg [0:1];  // Storage words
  logic       wr_ptr_reg;     // Write slot
  logic       rd_ptr_reg;     // Read slot
  logic [1:0] cnt_reg;        // Fill level

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      if (in_valid && in_ready) wr_ptr_reg <= ~wr_ptr_reg;
      if (out_valid && out_ready) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
    end
  end

  // Word storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
    end else if (in_valid && in_ready) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule // sfcp_skid

/* verif/sfcp_checker.sv */
// Pin-level checks on the serial flash command port
`timescale 1ns/1ps
`include "sfcp_consts.svh"
module sfcp_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Serial and control pins
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       wp_n,
  input wire logic       reset_pin_n,
  input wire logic       so_oe,
  input wire logic       rdy_busy_o,
  input wire logic       rdy_busy_oe,
  // Write stream and command fields
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_data,
  input wire logic [9:0] page_select_bits,
  input wire logic       cmd_refused,
  input wire logic       mode3
);
  logic [15:0] busy_cnt;  // Cycles spent in the current busy period
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts busy cycles, cleared while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 16'h0000;
    end else if (rdy_busy_oe) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end
  property p_oe_off; cs_n [*6] |-> !so_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("SO driven while deselected");
  property p_busy_start; $rose(rdy_busy_oe) |-> cs_n && $past(cs_n, 2); endproperty
  a_busy_start: assert property (p_busy_start) else $error("Busy began inside a frame");
  property p_busy_hold; $rose(rdy_busy_oe) |=> rdy_busy_oe [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Busy dropped early");
  property p_busy_len; $fell(rdy_busy_oe) && reset_pin_n |-> busy_cnt == `SFCP_BUSY_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("Busy period of wrong length");
  property p_rb_low; rdy_busy_oe |-> !rdy_busy_o; endproperty
  a_rb_low: assert property (p_rb_low) else $error("Ready/busy driven high");
  property p_rst_pin; !reset_pin_n [*4] |-> mode3 && !rdy_busy_oe && !so_oe; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("Not idle under reset pin");
  property p_mode_sel; $fell(cs_n) && reset_pin_n |-> ##6 (mode3 == sck); endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("Mode not taken from clock level");
  property p_protect; $rose(cmd_refused) |-> !wp_n && page_select_bits < `SFCP_PROT_PAGES; endproperty
  a_protect: assert property (p_protect) else $error("Refusal outside protected pages");
  // Stalled word held steady
  property p_wr_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("Write word lost during stall");
endmodule // sfcp_checker
bind sfcp_port sfcp_checker sfcp_checker_inst (
  .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .wp_n(wp_n), .reset_pin_n(reset_pin_n),
  .so_oe(so_oe), .rdy_busy_o(rdy_busy_o), .rdy_busy_oe(rdy_busy_oe), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_data(wr_data), .page_select_bits(page_select_bits),
  .cmd_refused(cmd_refused), .mode3(mode3)
);

/* verif/sfcp_host.sv */
// Host serial master that frames commands for the command port
`timescale 1ns/1ps
module sfcp_host (
  // Alignment clock
  input wire logic clk,
  // Serial pins
  output logic     sck,
  output logic     cs_n,
  output logic     si,
  input wire logic so
);
  logic idle_lvl;  // Clock level between frames
  int   gap;       // Extra pause after each byte, ns
  // Deselected, clock still
  initial begin
    sck = 1'b1;
    cs_n = 1'b1;
    si = 1'b0;
    idle_lvl = 1'b1;
    gap = 0;
  end
  task start(input logic lvl);
    @(negedge clk);
    idle_lvl = lvl;
    sck = lvl;
    #250;
    cs_n = 1'b0;
    #250;
  endtask
  // MSB first, set low, sample rise
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      #40;
      rx[i] = so;
      sck = 1'b1;
      #40;
    end
    #(gap);
  endtask
  task stop;
    if (!idle_lvl) begin
      sck = 1'b0;
    end
    #250;
    cs_n = 1'b1;
    // Released line shows inverse
    si = ~si;
    #250;
  endtask
endmodule // sfcp_host

/* verif/sfcp_port_tb.sv */
// Self-checking bench for the serial flash command port
`timescale 1ns/1ps
`include "sfcp_consts.svh"
module sfcp_port_tb;
  // Pins and streams
  logic       clk, rst_n, sck, cs_n, si, wp_n, reset_pin_n, wr_ready, cmp_equal;
  logic       so_o, so_oe, rdy_busy_o, rdy_busy_oe, wr_valid, cmd_refused, mode3, rd_req;
  logic [7:0] wr_data, cmd_opcode, rd_data;
  logic [9:0] page_select_bits;
  logic [8:0] byte_offset_bits;
  wire        so_wire = so_oe ? so_o : 1'bz;             // Floats when off
  wire        rb_wire = rdy_busy_oe ? rdy_busy_o : 1'b1; // Pull-up
  int         fails, tests_run, cyc, rdq;
  logic [7:0] got[$];                                    // Drained write bytes
  sfcp_port sfcp_port_inst (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
    .wp_n(wp_n), .reset_pin_n(reset_pin_n), .rdy_busy_o(rdy_busy_o), .rdy_busy_oe(rdy_busy_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .cmd_opcode(cmd_opcode),
    .page_select_bits(page_select_bits), .byte_offset_bits(byte_offset_bits),
    .cmd_refused(cmd_refused), .rd_data(rd_data), .rd_req(rd_req), .cmp_equal(cmp_equal), .mode3(mode3)
  );
  sfcp_host sfcp_host_inst (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_wire));
  // Clock and collection
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) if (wr_valid && wr_ready) got.push_back(wr_data);
  always @(posedge clk) if (rd_req) rdq++;
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_sim;
    end
  end
  task check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Opcode and three address bytes
  task cmd(input logic [7:0] op, input logic [9:0] pg, input logic [8:0] bo, input logic lvl);
    logic [23:0] a;
    logic [7:0]  r;
    a = {5'h00, pg, bo};
    sfcp_host_inst.start(lvl);
    sfcp_host_inst.xfer(op, r);
    for (int i = 2; i >= 0; i--) sfcp_host_inst.xfer(a[i*8 +: 8], r);
  endtask
  // Dummy bytes, then one data byte
  task rd(input int nd, output logic [7:0] b);
    repeat (nd) sfcp_host_inst.xfer(8'h00, b);
    sfcp_host_inst.xfer(8'h00, b);
  endtask
  task stat(output logic [7:0] s);
    sfcp_host_inst.start(1'b1);
    sfcp_host_inst.xfer(`SFCP_OP_STAT_RD, s);
    sfcp_host_inst.xfer(8'h00, s);
    sfcp_host_inst.stop;
  endtask
  // Bounded wait for ready, checked
  // next array command waits for ready
  task wait_rdy;
    int n;
    n = 0;
    while (rb_wire !== 1'b1 && n < 1100) begin
      @(negedge clk);
      n++;
    end
    check(n < 1100, 1'b1);
  endtask
  task t_start;
    check({mode3, so_oe, rb_wire, wr_valid}, 4'hA);
    $display("t_start done");
  endtask
  task t_read;
    logic [7:0] b;
    int         q0;
    for (int m = 0; m < 2; m++) begin
      q0 = rdq;
      cmd(m ? `SFCP_OP_PAGE_RD_S : `SFCP_OP_PAGE_RD, 10'h2A5, 9'h1C3, m[0]);
      rd(4, b);
      check(b, rd_data);
      check(rdq - q0, 1);
      check(mode3, m[0]);
      check(cmd_opcode, m ? `SFCP_OP_PAGE_RD_S : `SFCP_OP_PAGE_RD);
      check({page_select_bits, byte_offset_bits}, {10'h2A5, 9'h1C3});
      sfcp_host_inst.stop;
      check({rb_wire, so_oe}, 2'h2);
    end
    $display("t_read done");
  endtask
  task t_bufwr;
    logic [7:0] b;
    wr_ready = 1'b0;
    sfcp_host_inst.gap = 400;
    cmd(`SFCP_OP_BUF1_WR, 10'h3FF, 9'h005, 1'b0);
    sfcp_host_inst.xfer(8'hA1, b);
    sfcp_host_inst.xfer(8'hB2, b);
    sfcp_host_inst.stop;
    sfcp_host_inst.gap = 0;
    check({wr_valid, rb_wire, got.size() == 0}, 3'h7);
    check(byte_offset_bits, 9'h005);
    wr_ready = 1'b1;
    repeat (6) @(negedge clk);
    check({got.size() == 2, got[0], got[1]}, {1'b1, 16'hA1B2});
    $display("t_bufwr done");
  endtask
  task t_busy;
    logic [7:0] b;
    cmd(`SFCP_OP_XFR_B1, 10'h12C, 9'h000, 1'b1);
    sfcp_host_inst.stop;
    check(rb_wire, 1'b0);
    cmd(`SFCP_OP_BUF2_RD, 10'h000, 9'h010, 1'b1);
    rd(1, b);
    sfcp_host_inst.stop;
    check(b, rd_data);
    stat(b);
    check(b[7], 1'b0);
    wait_rdy;
    for (int e = 0; e < 2; e++) begin
      cmp_equal = e[0];
      cmd(`SFCP_OP_CMP_B1, 10'h12C, 9'h000, 1'b1);
      sfcp_host_inst.stop;
      cmd(`SFCP_OP_BUF1_RD, 10'h000, 9'h010, 1'b1);
      rd(1, b);
      check(so_oe, 1'b0);
      sfcp_host_inst.stop;
      wait_rdy;
      stat(b);
      check(b[7:6], {1'b1, ~e[0]});
    end
    $display("t_busy done");
  endtask
  task t_protect;
    logic [9:0] pg [3];
    pg = '{10'h0FF, 10'h100, 10'h0FF};
    for (int k = 0; k < 3; k++) begin
      wp_n = (k == 2);
      cmd(k == 0 ? `SFCP_OP_PG_ERASE : `SFCP_OP_PROG_E_B1, pg[k], 9'h000, 1'b1);
      sfcp_host_inst.stop;
      check({rb_wire, cmd_refused}, k == 0 ? 2'h3 : 2'h0);
      wait_rdy;
    end
    $display("t_protect done");
  endtask
  task t_unknown;
    logic [7:0] b;
    cmd(8'h8A, 10'h155, 9'h0AA, 1'b1);
    sfcp_host_inst.xfer(8'h3C, b);
    sfcp_host_inst.stop;
    check({rb_wire, wr_valid, so_oe}, 3'h4);
    check(page_select_bits, 10'h0FF);
    $display("t_unknown done");
  endtask
  task t_rstpin;
    logic [7:0] b;
    cmd(`SFCP_OP_PROG_E_B2, 10'h200, 9'h000, 1'b0);
    sfcp_host_inst.stop;
    check(rb_wire, 1'b0);
    reset_pin_n = 1'b0;
    repeat (8) @(negedge clk);
    check({rb_wire, mode3}, 2'h3);
    reset_pin_n = 1'b1;
    repeat (5) @(negedge clk);
    stat(b);
    check(b[7], 1'b1);
    $display("t_rstpin done");
  endtask
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    reset_pin_n = 1'b1;
    wr_ready = 1'b1;
    cmp_equal = 1'b1;
    rd_data = 8'h5A;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_start;
    t_read;
    t_bufwr;
    t_busy;
    t_protect;
    t_unknown;
    t_rstpin;
    end_sim;
  end
endmodule // sfcp_port_tb
